/* hw/msc_pkg.sv */
// Shared constants and types of the motor starter command block
package msc_pkg;

    ////////////////////
    localparam int ADDR_W = 4;
    localparam int DATA_W = 32;

    localparam logic [3:0] REG_CTRL_OFS = 4'h0;
    localparam logic [3:0] REG_STAT_OFS = 4'h4;

    localparam int CTRL_W          = 4;
    localparam int CTRL_UNDERCUR   = 0;
    localparam int CTRL_DIAG       = 1;
    localparam int CTRL_QUICKSTOP  = 2;
    localparam int CTRL_STD_PROF   = 3;
    localparam logic [3:0] CTRL_RST = 4'h0;

    localparam int STAT_FLAGS_LSB = 0;
    localparam int STAT_DIAG_LSB  = 8;
    localparam int STAT_TRIP_LSB  = 12;

    ////////////////////
    // Timing counts: clock cycles per ms tick, then times in ms ticks
    localparam int TICK_CYCLES   = 200_000;  // 1 ms
    localparam int HOLD_MS       = 1_000;
    localparam int RESTART_MS    = 60_000;
    localparam int FLASH_MS      = 250;
    localparam int DEBOUNCE_MS   = 10;
    localparam int MS_CNT_W      = 16;

    ////////////////////
    // Percent thresholds of rated current and thermal model limit
    localparam logic [7:0] UNDERCUR_PCT = 8'h19;  // 25
    localparam logic [7:0] OVERLOAD_PCT = 8'h6e;  // 110
    localparam logic [7:0] WARN_PCT     = 8'h5a;  // 90
    localparam logic [7:0] LOAD_PCT     = 8'h46;  // 70

    // Diagnostic codes, bit 3 is status bit 1 and bit 0 is status bit 4
    localparam logic [3:0] CODE_NONE      = 4'h0;
    localparam logic [3:0] CODE_CONDUCT   = 4'h2;
    localparam logic [3:0] CODE_OVERLOAD  = 4'h4;
    localparam logic [3:0] CODE_THERMIST  = 4'h6;
    localparam logic [3:0] CODE_MANUAL    = 4'h8;
    localparam logic [3:0] CODE_WARN      = 4'ha;
    localparam logic [3:0] CODE_LOAD      = 4'hd;
    localparam logic [3:0] CODE_GENERIC   = 4'he;

    ////////////////////
    // Index of each pin in the synchronised vector
    localparam int SYN_KEY_OFF  = 0;
    localparam int SYN_KEY_MAN  = 1;
    localparam int SYN_SENS_A   = 2;
    localparam int SYN_SENS_B   = 3;
    localparam int SYN_THERMIST = 4;
    localparam int SYN_CONDUCT  = 5;
    localparam int SYN_PM_FAULT = 6;
    localparam int SYN_MAN_CW   = 7;
    localparam int SYN_MAN_CCW  = 8;
    localparam int SYN_W        = 9;

    typedef enum logic [1:0] {
        FLT_NONE,
        FLT_WAIT,
        FLT_READY
    } msc_fault_e;

endpackage

/* hw/msc_pins_if.sv */
// Raw pin levels and their synchronised copies
`timescale 1ns/1ps
interface msc_pins_if #(parameter int W = 1);
    logic [W-1:0] raw;
    logic [W-1:0] sync;
    modport sync_side (input raw, output sync);
    modport user      (output raw, input sync);
endinterface

/* hw/msc_sync.sv */
// Two-stage synchroniser for asynchronous pin inputs
`timescale 1ns/1ps
module msc_sync #(
    parameter int W = 1
) (
    input  wire logic clk_sys,             // System clock
    input  wire logic reset,               // Sync reset, active high
    msc_pins_if.sync_side pins             // Raw in, synced out
);
    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
    } msc_sync_s;

    msc_sync_s s_r;
    msc_sync_s s_nxt;

    always_comb begin
        s_nxt    = s_r;
        s_nxt.s1 = pins.raw;
        s_nxt.s2 = s_r.s1;
    end

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign pins.sync = s_r.s2;
endmodule // msc_sync

/* hw/msc_tick.sv */
// Millisecond tick generator
`timescale 1ns/1ps
module msc_tick #(
    parameter int TICK_CYCLES = 200000
) (
    input  wire logic clk_sys,             // System clock
    input  wire logic reset,               // Sync reset, active high
    output logic      tick                 // One-cycle pulse per ms
);
    localparam int CW = $clog2(TICK_CYCLES + 1);

    typedef struct packed {
        logic [CW-1:0] cnt;
        logic          tick;
    } msc_tick_s;

    msc_tick_s s_r;
    msc_tick_s s_nxt;

    always_comb begin
        s_nxt      = s_r;
        s_nxt.tick = 1'b0;
        if (s_r.cnt == CW'(TICK_CYCLES - 1)) begin
            s_nxt.cnt  = '0;
            s_nxt.tick = 1'b1;
        end else begin
            s_nxt.cnt = s_r.cnt + 1'b1;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign tick = s_r.tick;
endmodule // msc_tick

/* hw/msc_starter.sv */
// Motor starter command decode, fault handling and diagnostics
//
// The placing of the registers and the strobed register port were left to the implementer.
`timescale 1ns/1ps
module msc_starter
    import msc_pkg::*;
#(
    parameter int TICK_CYCLES = msc_pkg::TICK_CYCLES,
    parameter int HOLD_MS     = msc_pkg::HOLD_MS,
    parameter int RESTART_MS  = msc_pkg::RESTART_MS,
    parameter int FLASH_MS    = msc_pkg::FLASH_MS,
    parameter int DEBOUNCE_MS = msc_pkg::DEBOUNCE_MS
) (
    input  wire logic                        clk_sys,        // Clock
    input  wire logic                        reset,          // Sync reset
    // Register port
    input  wire logic [msc_pkg::ADDR_W-1:0]  addr,           // Byte addr
    input  wire logic [msc_pkg::DATA_W-1:0]  wr_data,        // Write data
    input  wire logic                        wr_en,          // Write strobe
    input  wire logic                        rd_en,          // Read strobe
    output logic      [msc_pkg::DATA_W-1:0]  rd_data,        // Read data
    // Fieldbus output bits, same clock
    input  wire logic                        cmd_forward_bit,   // Fwd
    input  wire logic                        cmd_reverse_bit,   // Rev
    input  wire logic                        cmd_actuator_bit,  // Aux
    input  wire logic                        cmd_quickstop_suppress_bit,
    // Fieldbus input bits
    output logic                             stat_auto_mode_bit,   // Auto
    output logic                             stat_group_fault_bit, // 0=flt
    output logic                             stat_sensor_a_bit,    // Sens A
    output logic                             stat_sensor_b_bit,    // Sens B
    // Asynchronous pins
    input  wire logic                        key_off_pin,     // Key OFF
    input  wire logic                        key_manual_pin,  // Key manual
    input  wire logic                        sensor_input_a,  // Sensor A
    input  wire logic                        sensor_input_b,  // Sensor B
    input  wire logic                        thermistor_open, // Open/high R
    input  wire logic                        output_conducting, // Sensed on
    input  wire logic                        power_module_fault, // Other
    input  wire logic                        manual_cw_sel,   // Manual fwd
    input  wire logic                        manual_ccw_sel,  // Manual rev
    // Measurements from power module logic, same clock
    input  wire logic [7:0]                  thermal_pct,     // Model %
    input  wire logic [7:0]                  min_phase_pct,   // Lowest I %
    // Drive and indication
    output logic                             clockwise_run,        // Fwd
    output logic                             counterclockwise_run, // Rev
    output logic                             aux_actuator_output,  // Aux
    output logic                             motor_led_red,        // LED
    // Diagnostic channel
    output logic                             diag_code_bit1,  // Status 1
    output logic                             diag_code_bit2,  // Status 2
    output logic                             diag_code_bit3,  // Status 3
    output logic                             diag_code_bit4,  // Status 4
    output logic                             diag_group_error, // Column
    output logic                             peripheral_error_flag // Flag
);

    ////////////////////
    typedef struct packed {
        logic [CTRL_W-1:0]   ctrl;
        logic [DATA_W-1:0]   rd_data;
        msc_fault_e          fstate;
        logic [3:0]          trip_code;
        logic                trip_per;
        logic [MS_CNT_W-1:0] wait_cnt;
        logic [MS_CNT_W-1:0] hold_cnt;
        logic [MS_CNT_W-1:0] deb_cnt;
        logic [MS_CNT_W-1:0] flash_cnt;
        logic                flash_ph;
        logic [1:0]          key_deb;
        logic [1:0]          fb_dir_prev;
        logic                qs_stop;
        logic [1:0]          qs_dir;
        logic                run_cw;
        logic                run_ccw;
        logic                aux;
        logic [3:0]          fb_stat;
        logic                led;
        logic [3:0]          diag;
        logic                diag_grp;
        logic                diag_per;
    } msc_state_s;

    msc_state_s s_r;
    msc_state_s s_nxt;

    logic ms_tick;

    msc_pins_if #(.W(SYN_W)) pins ();

    ////////////////////
    // Pins pass two flops first
    assign pins.raw[SYN_KEY_OFF]  = key_off_pin;
    assign pins.raw[SYN_KEY_MAN]  = key_manual_pin;
    assign pins.raw[SYN_SENS_A]   = sensor_input_a;
    assign pins.raw[SYN_SENS_B]   = sensor_input_b;
    assign pins.raw[SYN_THERMIST] = thermistor_open;
    assign pins.raw[SYN_CONDUCT]  = output_conducting;
    assign pins.raw[SYN_PM_FAULT] = power_module_fault;
    assign pins.raw[SYN_MAN_CW]   = manual_cw_sel;
    assign pins.raw[SYN_MAN_CCW]  = manual_ccw_sel;

    msc_sync #(.W(SYN_W)) u_sync (
        .clk_sys (clk_sys),
        .reset   (reset),
        .pins    (pins)
    );

    msc_tick #(.TICK_CYCLES(TICK_CYCLES)) u_tick (
        .clk_sys (clk_sys),
        .reset   (reset),
        .tick    (ms_tick)
    );

    ////////////////////
    always_comb begin
        logic [1:0]  key_raw;
        logic        key_off;
        logic        auto_mode;
        logic        sens_a;
        logic        sens_b;
        logic [1:0]  fb_dir;
        logic [1:0]  dir;
        logic        key_reset;
        logic        fb_reset;
        logic        reset_req;
        logic        running;
        logic        undercur;
        logic        overload;
        logic        fault_now;
        logic [3:0]  fault_code;
        logic        fault_per;
        logic        qs_active;
        logic        drive_en;
        logic [3:0]  code;
        logic [DATA_W-1:0] stat_word;

        s_nxt         = s_r;
        s_nxt.rd_data = '0;

        key_raw   = {pins.sync[SYN_KEY_MAN], pins.sync[SYN_KEY_OFF]};
        key_off   = s_r.key_deb[0];
        auto_mode = ~s_r.key_deb[0] & ~s_r.key_deb[1];
        sens_a    = pins.sync[SYN_SENS_A];
        sens_b    = pins.sync[SYN_SENS_B];
        fb_dir    = {cmd_reverse_bit, cmd_forward_bit};
        running   = s_r.run_cw | s_r.run_ccw;

        // Key position must stay put a while
        if (key_raw == s_r.key_deb) begin
            s_nxt.deb_cnt = '0;
        end else if (ms_tick) begin
            if (s_r.deb_cnt == MS_CNT_W'(DEBOUNCE_MS - 1)) begin
                s_nxt.key_deb = key_raw;
                s_nxt.deb_cnt = '0;
            end else begin
                s_nxt.deb_cnt = s_r.deb_cnt + 1'b1;
            end
        end

        // One pulse per OFF hold
        key_reset = key_off & ms_tick &
                    (s_r.hold_cnt == MS_CNT_W'(HOLD_MS - 1));
        if (!key_off) begin
            s_nxt.hold_cnt = '0;
        end else if (ms_tick &&
                     s_r.hold_cnt != MS_CNT_W'(HOLD_MS)) begin
            s_nxt.hold_cnt = s_r.hold_cnt + 1'b1;
        end

        // Reset on entry into 11 only, not while it is held
        fb_reset = (fb_dir == 2'b11) &&
                   (s_r.fb_dir_prev != 2'b11);
        s_nxt.fb_dir_prev = fb_dir;
        reset_req = key_reset | fb_reset;

        ////////////////////
        // Fault sources, most specific code first
        overload = thermal_pct >= OVERLOAD_PCT;
        undercur = s_r.ctrl[CTRL_UNDERCUR] & running &
                   (min_phase_pct < UNDERCUR_PCT);
        fault_per  = 1'b0;
        fault_code = CODE_NONE;
        fault_now  = 1'b1;
        if (pins.sync[SYN_CONDUCT] && !running) begin
            fault_code = CODE_CONDUCT;
            fault_per  = 1'b1;
        end else if (overload) begin
            fault_code = CODE_OVERLOAD;
        end else if (pins.sync[SYN_THERMIST]) begin
            fault_code = CODE_THERMIST;
        end else if (pins.sync[SYN_PM_FAULT] || undercur) begin
            fault_code = CODE_GENERIC;
        end else begin
            fault_now = 1'b0;
        end

        // Trip, lockout, wait for reset
        case (s_r.fstate)
            FLT_NONE: begin
                if (fault_now) begin
                    s_nxt.fstate    = FLT_WAIT;
                    s_nxt.trip_code = fault_code;
                    s_nxt.trip_per  = fault_per;
                    s_nxt.wait_cnt  = '0;
                end
            end
            FLT_WAIT: begin
                if (ms_tick) begin
                    if (s_r.wait_cnt ==
                        MS_CNT_W'(RESTART_MS - 1)) begin
                        s_nxt.fstate = FLT_READY;
                    end else begin
                        s_nxt.wait_cnt = s_r.wait_cnt + 1'b1;
                    end
                end
            end
            FLT_READY: begin
                // A fault still present cannot be reset away
                if (!fault_now && reset_req) begin
                    s_nxt.fstate = FLT_NONE;
                end
            end
            default: begin
                s_nxt.fstate = FLT_NONE;
            end
        endcase

        // Flash phase free-runs so a flashing LED starts at once
        if (ms_tick) begin
            if (s_r.flash_cnt == MS_CNT_W'(FLASH_MS - 1)) begin
                s_nxt.flash_cnt = '0;
                s_nxt.flash_ph  = ~s_r.flash_ph;
            end else begin
                s_nxt.flash_cnt = s_r.flash_cnt + 1'b1;
            end
        end

        case (s_r.fstate)
            FLT_WAIT:  s_nxt.led = 1'b1;
            FLT_READY: s_nxt.led = fault_now | s_r.flash_ph;
            default:   s_nxt.led = 1'b0;
        endcase

        ////////////////////
        // Quick stop; a new stop beats a clear
        qs_active = s_r.ctrl[CTRL_QUICKSTOP] &
                    ~cmd_quickstop_suppress_bit;
        if (qs_active && (sens_a || sens_b)) begin
            s_nxt.qs_stop = 1'b1;
            s_nxt.qs_dir  = auto_mode ? fb_dir : 2'b00;
        end else if (s_r.qs_stop) begin
            if ((auto_mode && fb_dir != s_r.qs_dir) ||
                (!auto_mode && key_reset)) begin
                s_nxt.qs_stop = 1'b0;
            end
        end

        // Direction source follows key mode
        dir = auto_mode ? fb_dir :
              {pins.sync[SYN_MAN_CCW], pins.sync[SYN_MAN_CW]};
        drive_en = (s_r.fstate == FLT_NONE) & ~fault_now &
                   ~s_r.qs_stop & ~key_off;
        s_nxt.run_cw  = drive_en & (dir == 2'b01);
        s_nxt.run_ccw = drive_en & (dir == 2'b10);
        s_nxt.aux     = cmd_actuator_bit;

        s_nxt.fb_stat = {sens_b, sens_a,
                         s_r.fstate == FLT_NONE,
                         auto_mode};

        ////////////////////
        // Diag code; trip, mode, thermal
        s_nxt.diag_grp = 1'b0;
        s_nxt.diag_per = 1'b0;
        if (s_r.fstate != FLT_NONE) begin
            code           = s_r.trip_code;
            s_nxt.diag_grp = 1'b1;
            s_nxt.diag_per = s_r.trip_per;
        end else if (s_r.key_deb[1]) begin
            code = CODE_MANUAL;
        end else if (thermal_pct >= WARN_PCT) begin
            code = CODE_WARN;
        end else if (thermal_pct >= LOAD_PCT) begin
            code = CODE_LOAD;
        end else begin
            code = CODE_NONE;
        end
        if (!s_r.ctrl[CTRL_STD_PROF]) begin
            code[0] = 1'b0;
        end
        if (!s_r.ctrl[CTRL_DIAG]) begin
            code           = CODE_NONE;
            s_nxt.diag_grp = 1'b0;
            s_nxt.diag_per = 1'b0;
        end
        s_nxt.diag = code;

        ////////////////////
        // Register port; unmapped reads return zero
        stat_word = '0;
        stat_word[STAT_FLAGS_LSB +: 7] = {s_r.led, s_r.run_ccw,
                                          s_r.run_cw, auto_mode,
                                          s_r.qs_stop, fault_now,
                                          s_r.fstate != FLT_NONE};
        stat_word[STAT_DIAG_LSB +: 4] = s_r.diag;
        stat_word[STAT_TRIP_LSB +: 4] = s_r.trip_code;

        if (wr_en && addr == REG_CTRL_OFS) begin
            s_nxt.ctrl = wr_data[CTRL_W-1:0];
        end
        if (rd_en) begin
            case (addr)
                REG_CTRL_OFS: s_nxt.rd_data = DATA_W'(s_r.ctrl);
                REG_STAT_OFS: s_nxt.rd_data = stat_word;
                default:      s_nxt.rd_data = '0;
            endcase
        end
    end

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            s_r      <= '0;
            s_r.ctrl <= CTRL_RST;
        end else begin
            s_r <= s_nxt;
        end
    end

    ////////////////////
    assign rd_data              = s_r.rd_data;
    assign stat_auto_mode_bit   = s_r.fb_stat[0];
    assign stat_group_fault_bit = s_r.fb_stat[1];
    assign stat_sensor_a_bit    = s_r.fb_stat[2];
    assign stat_sensor_b_bit    = s_r.fb_stat[3];
    assign clockwise_run        = s_r.run_cw;
    assign counterclockwise_run = s_r.run_ccw;
    assign aux_actuator_output  = s_r.aux;
    assign motor_led_red        = s_r.led;
    assign diag_code_bit1       = s_r.diag[3];
    assign diag_code_bit2       = s_r.diag[2];
    assign diag_code_bit3       = s_r.diag[1];
    assign diag_code_bit4       = s_r.diag[0];
    assign diag_group_error     = s_r.diag_grp;
    assign peripheral_error_flag = s_r.diag_per;

endmodule // msc_starter

/* dv/msc_starter_checker.sv */
// Port assertions for the motor starter block
`timescale 1ns/1ps
module msc_starter_checker (
    input wire logic                       clk_sys,      // Clock
    input wire logic                       reset,        // Reset
    input wire logic [msc_pkg::ADDR_W-1:0] addr,         // Address
    input wire logic [msc_pkg::DATA_W-1:0] wr_data,      // Write data
    input wire logic                       wr_en,        // Write
    input wire logic                       cmd_forward_bit,      // Fwd
    input wire logic                       cmd_reverse_bit,      // Rev
    input wire logic                       cmd_actuator_bit,     // Aux
    input wire logic                       stat_auto_mode_bit,   // Auto
    input wire logic                       stat_group_fault_bit, // Fault
    input wire logic                       clockwise_run,        // Cw
    input wire logic                       counterclockwise_run, // Ccw
    input wire logic                       aux_actuator_output,  // Aux
    input wire logic                       motor_led_red,        // LED
    input wire logic                       diag_code_bit1,       // Bit 1
    input wire logic                       diag_code_bit4,       // Bit 4
    input wire logic                       diag_group_error,     // Column
    input wire logic                       peripheral_error_flag // Flag
);
    import msc_pkg::*;
    logic [3:0] ctrl_r;  // Shadow of CTRL
    always_ff @(posedge clk_sys) begin
        if (reset)
            ctrl_r <= CTRL_RST;
        else if (wr_en && addr == REG_CTRL_OFS)
            ctrl_r <= wr_data[3:0];
    end
    default clocking @(posedge clk_sys); endclocking
    default disable iff (reset);
    ////////////////////
    a_aux_follow: assert property (
        !$past(reset) |-> aux_actuator_output == $past(cmd_actuator_bit))
        else $error("aux output off command");
    a_diag_off: assert property (
        !$past(ctrl_r[CTRL_DIAG]) && !$past(ctrl_r[CTRL_DIAG], 2)
        |-> !diag_code_bit1 && !diag_group_error && !peripheral_error_flag)
        else $error("diag output while disabled");
    a_bit4_prof: assert property (
        !$past(ctrl_r[CTRL_STD_PROF]) && !$past(ctrl_r[CTRL_STD_PROF], 2)
        |-> !diag_code_bit4) else $error("bit4 without profile");
    a_fault_led: assert property (
        $fell(stat_group_fault_bit) |-> motor_led_red)
        else $error("fault without red lamp");
    a_cw_decode: assert property (
        clockwise_run && stat_auto_mode_bit && $past(stat_auto_mode_bit)
        |-> $past(cmd_forward_bit && !cmd_reverse_bit))
        else $error("cw run without cw command");
    a_ccw_decode: assert property (
        counterclockwise_run && stat_auto_mode_bit && $past(stat_auto_mode_bit)
        |-> $past(cmd_reverse_bit && !cmd_forward_bit))
        else $error("ccw run without ccw command");
    a_trip_stop: assert property (
        !stat_group_fault_bit |-> !clockwise_run && !counterclockwise_run)
        else $error("run while tripped");
    a_trip_hold: assert property (
        $fell(stat_group_fault_bit) |=> !stat_group_fault_bit [*8])
        else $error("trip released early");
    c_trip: cover property ($fell(stat_group_fault_bit));
    c_cw: cover property (clockwise_run);
    c_ccw: cover property (counterclockwise_run);
endmodule // msc_starter_checker

/* dv/msc_fb_master.sv */
// Fieldbus master model driving the four command bits
`timescale 1ns/1ps
module msc_fb_master (
    input  wire logic clk_sys,                   // Clock
    output logic      cmd_forward_bit,           // Fwd
    output logic      cmd_reverse_bit,           // Rev
    output logic      cmd_actuator_bit,          // Aux
    output logic      cmd_quickstop_suppress_bit // Ignore sensors
);
    initial begin
        {cmd_quickstop_suppress_bit, cmd_actuator_bit} = 2'h0;
        {cmd_reverse_bit, cmd_forward_bit} = 2'h0;
    end
    // Gap models a slow bus cycle
    task automatic send(input logic [3:0] v, input int gap);
        repeat (gap + 1) @(posedge clk_sys);
        {cmd_quickstop_suppress_bit, cmd_actuator_bit} <= v[3:2];
        {cmd_reverse_bit, cmd_forward_bit} <= v[1:0];
    endtask
endmodule // msc_fb_master

/* dv/msc_starter_tb.sv */
// Self-checking bench for the motor starter block
`timescale 1ns/1ps
module msc_starter_tb;
    import msc_pkg::*;
    logic              clk_sys = 1'h0;
    logic              reset = 1'h1;
    logic              wr_en = 1'h0;
    logic              rd_en = 1'h0;
    logic [ADDR_W-1:0] addr = '0;
    logic [DATA_W-1:0] wr_data = '0;
    logic [DATA_W-1:0] rd_data;
    logic [7:0]        thermal_pct = 8'h00;
    logic [7:0]        min_phase_pct = 8'h64;
    logic key_off_pin = 1'h0, key_manual_pin = 1'h0, thermistor_open = 1'h0;
    logic sensor_input_a = 1'h0, sensor_input_b = 1'h0;
    logic output_conducting = 1'h0, power_module_fault = 1'h0;
    logic manual_cw_sel = 1'h0, manual_ccw_sel = 1'h0;
    logic cmd_forward_bit, cmd_reverse_bit, cmd_actuator_bit;
    logic cmd_quickstop_suppress_bit, stat_auto_mode_bit;
    logic stat_group_fault_bit, stat_sensor_a_bit, stat_sensor_b_bit;
    logic clockwise_run, counterclockwise_run, aux_actuator_output;
    logic motor_led_red, diag_code_bit1, diag_code_bit2, diag_code_bit3;
    logic diag_code_bit4, diag_group_error, peripheral_error_flag, led_a;
    logic [7:0] pct_tbl [4] = '{8'h5a, 8'h59, 8'h46, 8'h45};
    logic [5:0] code_tbl [4] = '{6'h28, 6'h34, 6'h34, 6'h00};
    int n_mismatch = 0;
    int total_checks = 0;

    always #2.5 clk_sys = ~clk_sys;
    msc_fb_master i_msc_fb_master (.*);
    // Short tick keeps the minute wait brief
    msc_starter #(.TICK_CYCLES(10), .HOLD_MS(5), .RESTART_MS(20),
        .FLASH_MS(3), .DEBOUNCE_MS(2)) i_msc_starter (.*);
    ////////////////////
    function automatic logic [5:0] diag();
        return {diag_code_bit1, diag_code_bit2, diag_code_bit3,
                diag_code_bit4, diag_group_error, peripheral_error_flag};
    endfunction
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("wrong value at %0t: %h vs %h", $time, got, exp);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        wr_en <= 1'h1;
        addr <= a;
        wr_data <= d;
        @(posedge clk_sys);
        wr_en <= 1'h0;
    endtask
    task automatic rd(input logic [3:0] a, input logic [31:0] e);
        @(posedge clk_sys);
        rd_en <= 1'h1;
        addr <= a;
        @(posedge clk_sys);
        rd_en <= 1'h0;
        #1 chk(rd_data, e);
    endtask
    task automatic print_verdict();
        if (n_mismatch == 0 && total_checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    initial begin
        repeat (20000) @(posedge clk_sys);
        n_mismatch++;
        print_verdict();
    end
    initial begin
        repeat (4) @(posedge clk_sys);
        reset <= 1'h0;
        cyc(2);
        chk({stat_auto_mode_bit, stat_group_fault_bit}, 32'h3);
        rd(REG_CTRL_OFS, 32'h0);
        rd(4'h8, 32'h0);
        i_msc_fb_master.send(4'h4, 0);
        cyc(2);
        chk(aux_actuator_output, 32'h1);
        for (int i = 0; i < 4; i++) begin
            i_msc_fb_master.send(4'(i), i);
            cyc(2);
            chk({clockwise_run, counterclockwise_run}, {i == 1, i == 2});
        end
        chk(aux_actuator_output, 32'h0);
        i_msc_fb_master.send(4'h1, 0);
        sensor_input_a <= 1'h1;
        cyc(5);
        chk({stat_sensor_a_bit, clockwise_run}, 32'h3);
        i_msc_fb_master.send(4'h9, 0);
        sensor_input_a <= 1'h0;
        sensor_input_b <= 1'h1;
        cyc(5);
        chk({stat_sensor_a_bit, stat_sensor_b_bit, clockwise_run}, 32'h3);
        wr(REG_CTRL_OFS, 32'h4);
        cyc(3);
        chk(clockwise_run, 32'h1);
        i_msc_fb_master.send(4'h1, 0);
        cyc(4);
        chk(clockwise_run, 32'h0);
        @(posedge clk_sys) sensor_input_b <= 1'h0;
        cyc(8);
        chk(clockwise_run, 32'h0);
        i_msc_fb_master.send(4'h0, 0);
        i_msc_fb_master.send(4'h1, 2);
        cyc(2);
        chk(clockwise_run, 32'h1);
        wr(REG_CTRL_OFS, 32'ha);
        i_msc_fb_master.send(4'h0, 0);
        for (int i = 0; i < 4; i++) begin
            @(posedge clk_sys) thermal_pct <= pct_tbl[i];
            cyc(3);
            chk(diag(), code_tbl[i]);
        end
        @(posedge clk_sys) thermal_pct <= 8'h46;
        wr(REG_CTRL_OFS, 32'h2);
        cyc(3);
        chk(diag(), 32'h30);
        wr(REG_CTRL_OFS, 32'h0);
        cyc(3);
        chk(diag(), 32'h0);
        @(posedge clk_sys) thermal_pct <= 8'h00;
        wr(REG_CTRL_OFS, 32'h2);
        @(posedge clk_sys) key_manual_pin <= 1'h1;
        cyc(40);
        chk({stat_auto_mode_bit, diag()}, 32'h20);
        @(posedge clk_sys) key_manual_pin <= 1'h0;
        cyc(40);
        @(posedge clk_sys) thermistor_open <= 1'h1;
        cyc(6);
        chk({stat_group_fault_bit, motor_led_red, diag()}, 32'h5a);
        @(posedge clk_sys) thermistor_open <= 1'h0;
        i_msc_fb_master.send(4'h3, 0);
        cyc(5);
        chk(stat_group_fault_bit, 32'h0);
        i_msc_fb_master.send(4'h0, 0);
        cyc(230);
        led_a = motor_led_red;
        cyc(30);
        chk(motor_led_red, !led_a);
        @(posedge clk_sys) key_off_pin <= 1'h1;
        cyc(10);
        @(posedge clk_sys) key_off_pin <= 1'h0;
        cyc(20);
        chk(stat_group_fault_bit, 32'h0);
        @(posedge clk_sys) key_off_pin <= 1'h1;
        cyc(100);
        @(posedge clk_sys) key_off_pin <= 1'h0;
        cyc(40);
        chk(stat_group_fault_bit, 32'h1);
        @(posedge clk_sys) thermal_pct <= 8'h6e;
        cyc(6);
        chk(diag(), 32'h12);
        cyc(230);
        chk(motor_led_red, 32'h1);
        cyc(30);
        chk(motor_led_red, 32'h1);
        @(posedge clk_sys) thermal_pct <= 8'h00;
        i_msc_fb_master.send(4'h3, 0);
        cyc(5);
        chk(stat_group_fault_bit, 32'h1);
        wr(REG_CTRL_OFS, 32'h3);
        i_msc_fb_master.send(4'h1, 0);
        @(posedge clk_sys) min_phase_pct <= 8'h19;
        cyc(10);
        chk(stat_group_fault_bit, 32'h1);
        @(posedge clk_sys) min_phase_pct <= 8'h18;
        cyc(6);
        chk({clockwise_run, diag()}, 32'h3a);
        @(posedge clk_sys) min_phase_pct <= 8'h64;
        cyc(230);
        i_msc_fb_master.send(4'h3, 0);
        cyc(5);
        chk(stat_group_fault_bit, 32'h1);
        i_msc_fb_master.send(4'h0, 0);
        @(posedge clk_sys) output_conducting <= 1'h1;
        cyc(6);
        chk(diag(), 32'h0b);
        print_verdict();
    end
endmodule // msc_starter_tb
bind msc_starter msc_starter_checker i_msc_starter_checker (.*);
